/* adc_cfg_pkg.sv */
// Constants, types and helpers shared by the converter configuration logic
package adc_cfg_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [3:0] ADDR_STATUS = 4'h2; // Status byte readback
    localparam logic [3:0] ADDR_FILTER_SETUP = 4'h7; // Filter setup register
    localparam logic [3:0] ADDR_SERIAL_PORT = 4'h8; // Serial-port settings
    localparam logic [3:0] ADDR_MAP_CRC_REF = 4'hF; // Map CRC reference / scratchpad

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int BIT_CLK_SEL = 7;
    localparam int BIT_CLK_DIV = 6;
    localparam int BIT_OUT_STRENGTH = 5;
    localparam int BIT_RESERVED = 4;
    localparam int BIT_DATA16 = 3;
    localparam int BIT_LINK_CRC = 2;
    localparam int BIT_MAP_CRC = 1;
    localparam int BIT_STATUS_PREFIX = 0;
    localparam logic [7:0] SERIAL_PORT_WMASK = 8'hEF; // Reserved bit never stored
    localparam logic [7:0] SERIAL_PORT_RESET = 8'h00;
    localparam logic [4:0] FILTER_RESET = 5'h00;
    localparam logic [7:0] MAP_CRC_RESET = 8'h00;
    localparam int FILTER_MSB = 4;
    localparam int STAT_LINK_ERR_BIT = 2; // Status byte: link check error
    localparam int STAT_MAP_ERR_BIT = 1; // Status byte: map check error

    // ********************************************************
    // Filter code map
    // ********************************************************
    localparam logic [4:0] CODE_SINC4_FIRST = 5'h08;
    localparam logic [4:0] CODE_SINC4_LAST = 5'h12; // 10010: sinc4 OSR 4096
    localparam logic [4:0] CODE_S4S1_LAST = 5'h1B; // 10011..11011
    localparam logic [4:0] CODE_SINC3_A = 5'h1C; // 11100
    localparam logic [4:0] CODE_SINC3_B = 5'h1D; // 11101
    localparam logic [4:0] CODE_S3S1_A = 5'h1E; // 11110
    localparam logic [4:0] CODE_S3S1_B = 5'h1F; // 11111
    localparam logic [15:0] OSR_WIDE_BASE = 16'h0020; // 32, doubled per code
    localparam logic [15:0] OSR_SINC4_S1 = 16'h0020; // 32
    localparam logic [15:0] OSR_SINC3_A = 16'h682B; // 26667
    localparam logic [15:0] OSR_SINC3_B = 16'h7D00; // 32000
    localparam logic [9:0] OSR2_NONE = 10'h001;

    // Kind of digital filter selected
    typedef enum logic [2:0] {
        FILT_WIDEBAND,
        FILT_SINC4,
        FILT_SINC4_SINC1,
        FILT_SINC3,
        FILT_SINC3_SINC1
    } filter_kind_t;

    // ********************************************************
    // Link CRC
    // ********************************************************
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // One byte through the CRC-8 register, MSB first
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

/* link_crc_accum.sv */
// Running CRC-8 accumulator over a byte stream
`timescale 1ns/100ps
`default_nettype none
module link_crc_accum (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic restart_in, // Start a new frame
    input wire logic byte_valid_in, // Fold byte_in into the CRC
    input wire logic [7:0] byte_in,
    output logic [7:0] crc_out
);

    logic [7:0] crc_q;
    logic [7:0] crc_d;

    // Next value: restart has priority so a new frame never inherits old bytes
    always_comb begin
        crc_d = crc_q;
        if (restart_in) begin
            crc_d = adc_cfg_pkg::CRC_INIT;
        end else if (byte_valid_in) begin
            crc_d = adc_cfg_pkg::crc8_step(crc_q, byte_in);
        end
    end

    // Register
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            crc_q <= adc_cfg_pkg::CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc_out = crc_q;

endmodule
`default_nettype wire

/* adc_filter_and_interface_config.sv */
// Filter selection and serial-port settings register bank of the converter
`timescale 1ns/100ps
`default_nettype none
module adc_filter_and_interface_config (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Register access from the serial-port decoder
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Input frame bytes; the last byte of a frame is its CRC
    input wire logic rx_byte_valid_in,
    input wire logic rx_byte_last_in,
    input wire logic [7:0] rx_byte_in,
    // Output data bytes
    input wire logic tx_frame_start_in,
    input wire logic tx_byte_valid_in,
    input wire logic [7:0] tx_byte_in,
    output logic [7:0] tx_crc_out,
    // Internally computed register-map CRC
    input wire logic [7:0] map_crc_calc_in,
    // Decoded settings and error flags
    output logic clk_external_out,
    output logic clk_div8_out,
    output logic output_strength_select_out,
    output logic data_16bit_out,
    output logic link_crc_en_out,
    output logic map_crc_en_out,
    output logic status_prefix_out,
    output logic [2:0] filter_kind_out,
    output logic [15:0] osr_main_out,
    output logic [9:0] osr_avg_out,
    output logic link_err_out,
    output logic map_err_out
);

    // ********************************************************
    // Filter decode
    // ********************************************************

    // Main-stage OSR for each filter code
    function automatic logic [15:0] osr_main(input logic [4:0] code);
        logic [15:0] r;
        r = adc_cfg_pkg::OSR_SINC3_B;
        if (code < adc_cfg_pkg::CODE_SINC4_FIRST) begin
            r = adc_cfg_pkg::OSR_WIDE_BASE << code[2:0];
        end else if (code <= adc_cfg_pkg::CODE_SINC4_LAST) begin
            unique case (code)
                5'h08: r = 16'h000C;
                5'h09: r = 16'h0010;
                5'h0A: r = 16'h0018;
                5'h0B: r = 16'h0020;
                5'h0C: r = 16'h0040;
                5'h0D: r = 16'h0080;
                5'h0E: r = 16'h0100;
                5'h0F: r = 16'h0200;
                5'h10: r = 16'h0400;
                5'h11: r = 16'h0800;
                default: r = 16'h1000;
            endcase
        end else if (code <= adc_cfg_pkg::CODE_S4S1_LAST) begin
            r = adc_cfg_pkg::OSR_SINC4_S1;
        end else if (code == adc_cfg_pkg::CODE_SINC3_A) begin
            r = adc_cfg_pkg::OSR_SINC3_A;
        end else begin
            r = adc_cfg_pkg::OSR_SINC3_B;
        end
        return r;
    endfunction

    // Averaging-stage OSR; one where no sinc1 stage follows
    function automatic logic [9:0] osr_avg(input logic [4:0] code);
        logic [9:0] r;
        unique case (code)
            5'h13: r = 10'h002;
            5'h14: r = 10'h004;
            5'h15: r = 10'h00A;
            5'h16: r = 10'h014;
            5'h17: r = 10'h028;
            5'h18: r = 10'h064;
            5'h19: r = 10'h0C8;
            5'h1A: r = 10'h190;
            5'h1B: r = 10'h3E8;
            adc_cfg_pkg::CODE_S3S1_A: r = 10'h003;
            adc_cfg_pkg::CODE_S3S1_B: r = 10'h005;
            default: r = adc_cfg_pkg::OSR2_NONE;
        endcase
        return r;
    endfunction

    // Filter kind for each code
    function automatic adc_cfg_pkg::filter_kind_t filt_kind(input logic [4:0] code);
        adc_cfg_pkg::filter_kind_t k;
        if (code < adc_cfg_pkg::CODE_SINC4_FIRST) begin
            k = adc_cfg_pkg::FILT_WIDEBAND;
        end else if (code <= adc_cfg_pkg::CODE_SINC4_LAST) begin
            k = adc_cfg_pkg::FILT_SINC4;
        end else if (code <= adc_cfg_pkg::CODE_S4S1_LAST) begin
            k = adc_cfg_pkg::FILT_SINC4_SINC1;
        end else if (code <= adc_cfg_pkg::CODE_SINC3_B) begin
            k = adc_cfg_pkg::FILT_SINC3;
        end else begin
            k = adc_cfg_pkg::FILT_SINC3_SINC1;
        end
        return k;
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    logic [7:0] serial_port_settings_q; // Reserved bit held at zero
    logic [7:0] serial_port_settings_d;
    logic [4:0] filter_q; // Filter mode field of the setup register
    logic [4:0] filter_d;
    logic [7:0] map_crc_ref_q; // Map CRC reference or scratchpad
    logic [7:0] map_crc_ref_d;
    logic link_err_q; // Sticky link CRC error
    logic link_err_d;
    logic map_err_q; // Map CRC mismatch
    logic map_err_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] rx_crc; // Running CRC of the current input frame
    logic rx_mismatch;
    logic [7:0] status_byte;

    // Frame CRC over all bytes but the last
    link_crc_accum rx_crc_unit (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .restart_in(rx_byte_valid_in && rx_byte_last_in),
        .byte_valid_in(rx_byte_valid_in && !rx_byte_last_in),
        .byte_in(rx_byte_in),
        .crc_out(rx_crc)
    );

    // Output data CRC; the frame logic appends it when checks are on
    link_crc_accum tx_crc_unit (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .restart_in(tx_frame_start_in),
        .byte_valid_in(tx_byte_valid_in),
        .byte_in(tx_byte_in),
        .crc_out(tx_crc_out)
    );

    // Mismatch only counts while the link check is enabled
    assign rx_mismatch = rx_byte_valid_in && rx_byte_last_in && serial_port_settings_q[adc_cfg_pkg::BIT_LINK_CRC]
        && (rx_byte_in != rx_crc);

    // Status byte as seen by the host
    always_comb begin
        status_byte = 8'h00;
        status_byte[adc_cfg_pkg::STAT_LINK_ERR_BIT] = link_err_q;
        status_byte[adc_cfg_pkg::STAT_MAP_ERR_BIT] = map_err_q;
    end

    // ********************************************************
    // Next-state logic
    // ********************************************************

    // Register writes, flags and readback
    always_comb begin
        serial_port_settings_d = serial_port_settings_q;
        filter_d = filter_q;
        map_crc_ref_d = map_crc_ref_q;
        link_err_d = link_err_q;
        rdata_d = rdata_q;
        if (reg_wr_en_in) begin
            unique case (reg_addr_in)
                adc_cfg_pkg::ADDR_SERIAL_PORT: begin
                    // Reserved bit masked off so it can never be set
                    serial_port_settings_d = reg_wdata_in & adc_cfg_pkg::SERIAL_PORT_WMASK;
                end
                adc_cfg_pkg::ADDR_FILTER_SETUP: begin
                    filter_d = reg_wdata_in[adc_cfg_pkg::FILTER_MSB:0];
                end
                adc_cfg_pkg::ADDR_MAP_CRC_REF: begin
                    map_crc_ref_d = reg_wdata_in;
                end
                adc_cfg_pkg::ADDR_STATUS: begin
                    if (reg_wdata_in[adc_cfg_pkg::STAT_LINK_ERR_BIT]) begin
                        link_err_d = 1'b0;
                    end
                end
                default: begin
                    // Other addresses belong to other blocks
                end
            endcase
        end
        // A mismatch in the clearing cycle still sets the flag
        if (rx_mismatch) begin
            link_err_d = 1'b1;
        end
        // Map check follows the live comparison, off when disabled
        map_err_d = serial_port_settings_q[adc_cfg_pkg::BIT_MAP_CRC]
            && (map_crc_calc_in != map_crc_ref_q);
        if (reg_rd_en_in) begin
            unique case (reg_addr_in)
                adc_cfg_pkg::ADDR_SERIAL_PORT: rdata_d = serial_port_settings_q;
                adc_cfg_pkg::ADDR_FILTER_SETUP: rdata_d = {3'h0, filter_q};
                adc_cfg_pkg::ADDR_MAP_CRC_REF: rdata_d = map_crc_ref_q;
                adc_cfg_pkg::ADDR_STATUS: rdata_d = status_byte;
                default: rdata_d = 8'h00; // Unmapped here reads zero
            endcase
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************

    // All settings clear on reset
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            serial_port_settings_q <= adc_cfg_pkg::SERIAL_PORT_RESET;
            filter_q <= adc_cfg_pkg::FILTER_RESET;
            map_crc_ref_q <= adc_cfg_pkg::MAP_CRC_RESET;
            link_err_q <= 1'b0;
            map_err_q <= 1'b0;
            rdata_q <= 8'h00;
            clk_external_out <= 1'b0;
            clk_div8_out <= 1'b0;
            output_strength_select_out <= 1'b0;
            data_16bit_out <= 1'b0;
            link_crc_en_out <= 1'b0;
            map_crc_en_out <= 1'b0;
            status_prefix_out <= 1'b0;
            filter_kind_out <= adc_cfg_pkg::FILT_WIDEBAND;
            osr_main_out <= adc_cfg_pkg::OSR_WIDE_BASE;
            osr_avg_out <= adc_cfg_pkg::OSR2_NONE;
        end else begin
            serial_port_settings_q <= serial_port_settings_d;
            filter_q <= filter_d;
            map_crc_ref_q <= map_crc_ref_d;
            link_err_q <= link_err_d;
            map_err_q <= map_err_d;
            rdata_q <= rdata_d;
            // Decoded controls registered from the next value, so they track the register
            clk_external_out <= serial_port_settings_d[adc_cfg_pkg::BIT_CLK_SEL];
            clk_div8_out <= serial_port_settings_d[adc_cfg_pkg::BIT_CLK_DIV];
            output_strength_select_out <= serial_port_settings_d[adc_cfg_pkg::BIT_OUT_STRENGTH];
            data_16bit_out <= serial_port_settings_d[adc_cfg_pkg::BIT_DATA16];
            link_crc_en_out <= serial_port_settings_d[adc_cfg_pkg::BIT_LINK_CRC];
            map_crc_en_out <= serial_port_settings_d[adc_cfg_pkg::BIT_MAP_CRC];
            status_prefix_out <= serial_port_settings_d[adc_cfg_pkg::BIT_STATUS_PREFIX];
            filter_kind_out <= filt_kind(filter_d);
            osr_main_out <= osr_main(filter_d);
            osr_avg_out <= osr_avg(filter_d);
        end
    end

    assign reg_rdata_out = rdata_q;
    assign link_err_out = link_err_q;
    assign map_err_out = map_err_q;

endmodule
`default_nettype wire

/* adc_cfg_chk.sv */
// Assertion checker for the converter configuration register bank
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_chk (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic rx_byte_valid_in,
    input wire logic clk_external_out,
    input wire logic clk_div8_out,
    input wire logic output_strength_select_out,
    input wire logic data_16bit_out,
    input wire logic link_crc_en_out,
    input wire logic map_crc_en_out,
    input wire logic status_prefix_out,
    input wire logic [2:0] filter_kind_out,
    input wire logic [15:0] osr_main_out,
    input wire logic [9:0] osr_avg_out,
    input wire logic link_err_out,
    input wire logic map_err_out
);
    // ****************************************
    // Common clock and reset
    // ****************************************
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic wr_set; // Write aimed at the settings register
    logic wr_filt; // Write aimed at the filter setup register
    logic [6:0] bits_q; // Stored settings bits, reserved bit left out
    assign wr_set = reg_wr_en_in && (reg_addr_in == 4'h8);
    assign wr_filt = reg_wr_en_in && (reg_addr_in == 4'h7);
    assign bits_q = {clk_external_out, clk_div8_out, output_strength_select_out, data_16bit_out,
                     link_crc_en_out, map_crc_en_out, status_prefix_out};
    // ****************************************
    // Settings register
    // ****************************************
    property p_set_bits; wr_set |=> bits_q == {$past(reg_wdata_in[7:5]), $past(reg_wdata_in[3:0])}; endproperty
    a_set_bits: assert property (p_set_bits) else $error("settings outputs wrong");
    property p_hold; !wr_set |=> $stable(bits_q); endproperty
    a_hold: assert property (p_hold) else $error("settings changed without a write");
    property p_rsv; reg_rd_en_in && reg_addr_in == 4'h8 |=> !reg_rdata_out[4]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
    property p_unmapped; reg_rd_en_in && reg_addr_in == 4'h3 |=> reg_rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ****************************************
    // Filter code decoding
    // ****************************************
    property p_sinc4; wr_filt && reg_wdata_in[4:0] == 5'h12
        |=> filter_kind_out == 3'h1 && osr_main_out == 16'h1000 && osr_avg_out == 10'h001; endproperty
    a_sinc4: assert property (p_sinc4) else $error("code 12h decode wrong");
    property p_s4s1; wr_filt && reg_wdata_in[4:0] inside {[5'h13:5'h1B]}
        |=> filter_kind_out == 3'h2 && osr_main_out == 16'h0020; endproperty
    a_s4s1: assert property (p_s4s1) else $error("sinc4 plus sinc1 decode wrong");
    property p_sinc3; wr_filt && reg_wdata_in[4:0] == 5'h1C
        |=> filter_kind_out == 3'h3 && osr_main_out == 16'h682B; endproperty
    a_sinc3: assert property (p_sinc3) else $error("code 1Ch decode wrong");
    property p_s3s1; wr_filt && reg_wdata_in[4:0] == 5'h1F
        |=> filter_kind_out == 3'h4 && osr_main_out == 16'h7D00 && osr_avg_out == 10'h005; endproperty
    a_s3s1: assert property (p_s3s1) else $error("code 1Fh decode wrong");
    // ****************************************
    // Error flags
    // ****************************************
    property p_map_off; !map_crc_en_out && !reg_wr_en_in |=> !map_err_out; endproperty
    a_map_off: assert property (p_map_off) else $error("map error while check off");
    property p_link_off; !link_crc_en_out && !link_err_out && !reg_wr_en_in |=> !link_err_out; endproperty
    a_link_off: assert property (p_link_off) else $error("link error while check off");
    property p_link_clr; reg_wr_en_in && reg_addr_in == 4'h2 && reg_wdata_in[2] && !rx_byte_valid_in
        |=> !link_err_out; endproperty
    a_link_clr: assert property (p_link_clr) else $error("link error not cleared");
endmodule
bind adc_filter_and_interface_config adc_cfg_chk adc_cfg_chk_i (.*);
`default_nettype wire

/* host_frame_model.sv */
// Host-side model that sends input frames closed by a check byte
`timescale 1ns/100ps
`default_nettype none
module host_frame_model (
    input wire logic sys_clk_in,
    output logic rx_byte_valid_out,
    output logic rx_byte_last_out,
    output logic [7:0] rx_byte_out
);
    // Bit-serial CRC-8, polynomial 07h, seed FFh, MSB first
    function automatic logic [7:0] crc_of(input logic [7:0] seed, input logic [7:0] b);
        logic [7:0] c;
        c = seed;
        for (int i = 7; i >= 0; i--) begin
            c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    initial begin
        rx_byte_valid_out = 1'b0;
        rx_byte_last_out = 1'b0;
        rx_byte_out = 8'h00;
    end
    // Two payload bytes then the check byte; flip corrupts it on command
    task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] flip);
        logic [7:0] q [3];
        q[0] = b0;
        q[1] = b1;
        q[2] = crc_of(crc_of(8'hFF, b0), b1) ^ flip;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk_in);
            #1;
            rx_byte_valid_out = 1'b1;
            rx_byte_last_out = (k == 2);
            rx_byte_out = q[k];
        end
        @(posedge sys_clk_in);
        #1;
        rx_byte_valid_out = 1'b0;
        rx_byte_last_out = 1'b0;
        // A released line must not keep showing the last byte
        rx_byte_out = ~rx_byte_out;
    endtask
endmodule
`default_nettype wire

/* test_adc_filter_and_interface_config.sv */
// Self-checking testbench for the converter configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_adc_filter_and_interface_config;
    logic sys_clk_in, rstn_in, reg_wr_en_in, reg_rd_en_in, tx_frame_start_in, tx_byte_valid_in;
    logic rx_byte_valid_in, rx_byte_last_in, link_err_out, map_err_out;
    logic clk_external_out, clk_div8_out, output_strength_select_out, data_16bit_out;
    logic link_crc_en_out, map_crc_en_out, status_prefix_out;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, rx_byte_in, tx_byte_in, tx_crc_out, map_crc_calc_in, v;
    logic [2:0] filter_kind_out;
    logic [15:0] osr_main_out, want;
    logic [9:0] osr_avg_out;
    logic [4:0] code;
    logic [6:0] bits_seen; // Setting bits as one vector
    int n_errors = 0;
    int checked = 0;
    // Averaging ratios for codes 12h..1Fh, 1 where there is no averaging stage
    logic [9:0] avg_e [14] = '{10'h001, 10'h002, 10'h004, 10'h00A, 10'h014, 10'h028, 10'h064,
                               10'h0C8, 10'h190, 10'h3E8, 10'h001, 10'h001, 10'h003, 10'h005};
    assign bits_seen = {clk_external_out, clk_div8_out, output_strength_select_out, data_16bit_out,
                        link_crc_en_out, map_crc_en_out, status_prefix_out};
    adc_filter_and_interface_config adc_filter_and_interface_config_i (.*);
    host_frame_model host_frame_model_i (
        .sys_clk_in(sys_clk_in),
        .rx_byte_valid_out(rx_byte_valid_in),
        .rx_byte_last_out(rx_byte_last_in),
        .rx_byte_out(rx_byte_in)
    );
    // ****************************************
    // Clock, access tasks and verdict
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step();
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        step();
        reg_wr_en_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        step();
        reg_wr_en_in = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        step();
        reg_rd_en_in = 1'b1;
        reg_addr_in = a;
        step();
        reg_rd_en_in = 1'b0;
        d = reg_rdata_out;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #100000;
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        finish_test();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {rstn_in, reg_wr_en_in, reg_rd_en_in, tx_frame_start_in, tx_byte_valid_in} = 5'h00;
        {reg_addr_in, reg_wdata_in, tx_byte_in} = 20'h00000;
        map_crc_calc_in = 8'h5A;
        repeat (4) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        rd(4'h8, v);
        chk("settings", 16'h0000, {8'h00, v});
        rd(4'h7, v);
        chk("filter", 16'h0000, {8'h00, v});
        chk("osr_main", 16'h0020, osr_main_out);
        // Addresses owned by other blocks ignore writes and read zero here
        wr(4'h3, 8'hFF);
        rd(4'h3, v);
        chk("unmapped", 16'h0000, {8'h00, v});
        $display("Test reset values done");
        // Walking one through the settings byte
        for (int i = 0; i < 8; i++) begin
            wr(4'h8, 8'h01 << i);
            v = {1'b0, 7'(i < 4 ? 7'h01 << i : 7'h01 << (i - 1)) & 7'(i == 4 ? 7'h00 : 7'h7F)};
            chk("bits", {8'h00, v}, {9'h000, bits_seen});
            rd(4'h8, v);
            chk("settings", {8'h00, 8'h01 << i & 8'hEF}, {8'h00, v});
        end
        $display("Test settings bits done");
        // Upper filter codes, with junk in the unused upper bits
        for (int i = 0; i < 14; i++) begin
            code = 5'h12 + 5'(i);
            wr(4'h7, {3'h7, code});
            want = code == 5'h12 ? 16'h0001 : code <= 5'h1B ? 16'h0002 : code <= 5'h1D ? 16'h0003 : 16'h0004;
            chk("kind", want, {13'h0000, filter_kind_out});
            want = code == 5'h12 ? 16'h1000 : code <= 5'h1B ? 16'h0020 : code == 5'h1C ? 16'h682B : 16'h7D00;
            chk("osr_main", want, osr_main_out);
            chk("osr_avg", {6'h00, avg_e[i]}, {6'h00, osr_avg_out});
            rd(4'h7, v);
            chk("filter", {11'h000, code}, {8'h00, v});
        end
        $display("Test filter codes done");
        // Link check: good frame, bad frame, clear, then check off
        wr(4'h8, 8'h04);
        host_frame_model_i.send_frame(8'h12, 8'h34, 8'h00);
        chk("link_err", 16'h0000, {15'h0000, link_err_out});
        host_frame_model_i.send_frame(8'h12, 8'h34, 8'h01);
        chk("link_err", 16'h0001, {15'h0000, link_err_out});
        rd(4'h2, v);
        chk("status", 16'h0004, {8'h00, v});
        wr(4'h2, 8'h04);
        chk("link_err", 16'h0000, {15'h0000, link_err_out});
        wr(4'h8, 8'h00);
        host_frame_model_i.send_frame(8'hA0, 8'h0B, 8'h80);
        chk("link_err", 16'h0000, {15'h0000, link_err_out});
        step();
        tx_frame_start_in = 1'b1;
        step();
        {tx_frame_start_in, tx_byte_valid_in, tx_byte_in} = {2'h1, 8'hA5};
        step();
        tx_byte_in = 8'h3C;
        step();
        tx_byte_valid_in = 1'b0;
        want = {8'h00, host_frame_model_i.crc_of(host_frame_model_i.crc_of(8'hFF, 8'hA5), 8'h3C)};
        chk("tx_crc", want, {8'h00, tx_crc_out});
        $display("Test link check done");
        // Map check: match, mismatch, then scratchpad use
        wr(4'hF, 8'h5A);
        wr(4'h8, 8'h02);
        step();
        chk("map_err", 16'h0000, {15'h0000, map_err_out});
        wr(4'hF, 8'h5B);
        step();
        chk("map_err", 16'h0001, {15'h0000, map_err_out});
        rd(4'h2, v);
        chk("status", 16'h0002, {8'h00, v});
        wr(4'h8, 8'h00);
        step();
        chk("map_err", 16'h0000, {15'h0000, map_err_out});
        rd(4'hF, v);
        chk("scratch", 16'h005B, {8'h00, v});
        // Second reset in mid-run
        wr(4'h8, 8'hFF);
        rstn_in = 1'b0;
        step();
        rstn_in = 1'b1;
        chk("bits", 16'h0000, {9'h000, bits_seen});
        $display("Test map check and reset done");
        finish_test();
    end
endmodule
`default_nettype wire
